// [src/io_regs_defines.svh]
// Register offsets, field positions and reset values of the I/O supply and pin input slice.
// Assumes inclusion by the register block only.
`ifndef IO_REGS_DEFINES_SVH
`define IO_REGS_DEFINES_SVH
`define RESERVED_SLOT_A_ADDR 12'h00C
`define IO_SUPPLY_CONTROL_ADDR 12'h00D
`define PIN_LEVEL_STATUS_ADDR 12'h00E
`define PIN_INPUT_CONTROL_ADDR 12'h00F
`define BYTE_ADDR(idx) ((idx) << 2)
`define HV_SEL_BIT 7
`define OVERRIDE_BIT 6
`define SUPPLY_HI 5
`define SUPPLY_LO 4
`define SUPPLY_18V 2'h0
`define SUPPLY_33V 2'h3
`define RESERVED_SLOT_A_RST 8'h00
`define IO_SUPPLY_CONTROL_RST 8'h09
`define PIN_LEVEL_STATUS_RST 8'h00
`define PIN_INPUT_CONTROL_RST 8'h7F
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

// [src/io_regs_pkg.sv]
// Types shared by the I/O supply and pin input register block.
// Assumes the defines header supplies all numbers.
package io_regs_pkg;
    // Effective supply controls handed to the pad ring.
    typedef struct packed {
        logic high_voltage;
        logic [1:0] supply_level;
    } supply_ctrl_type;
    // Write-side state of the bus slave.
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_RESP
    } wr_state_type;
endpackage

// [src/io_supply_pin_regs.sv]
// AXI4-Lite register slice for I/O supply selection and general-purpose pin inputs.
// Assumes one clock; the detector level and pin levels are asynchronous to it.
// Notes on behaviour
// - Bit 7 selects 1.8 V or 3.3 V.
// - Override clear: detected level drives both controls.
// - Override set: written values drive the controls.
// - Supply field 00 is 1.8 V, 11 3.3 V.
// - Override clear: select bit reads detected level.
// - Override clear: supply field reads detected encoding.
// - Pin status bits are read-only live levels masked by the input enables.
// - Status bit n carries pin n.
// - Per-pin input enables, each resetting to one.
`timescale 1ns/1ps
`include "io_regs_defines.svh"
module io_supply_pin_regs (
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_NRST,
    // AXI4-Lite write address and data.
    input wire logic [11:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    // AXI4-Lite write response.
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // AXI4-Lite read channels.
    input wire logic [11:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Supply detector and pins.
    input wire logic I_DETECTED_3V3,
    input wire logic [3:0] I_PIN_LEVEL,
    // Controls to the pad ring.
    output io_regs_pkg::supply_ctrl_type O_SUPPLY_CTRL,
    output logic [3:0] O_PIN_INPUT_ENABLE
);

    logic [7:0] reserved_a_r;
    logic [7:0] io_ctl_r;
    logic [7:0] pin_rsvd_r;
    logic [7:0] in_ctl_r;
    logic det_meta_r;
    logic det_r;
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic [11:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic w_held_r;
    logic [3:0] wstrb_r;
    io_regs_pkg::wr_state_type wr_state_r;
    logic do_write;
    logic [1:0] det_code;
    io_regs_pkg::supply_ctrl_type eff_ctrl;
    logic [7:0] io_ctl_view;
    logic [31:0] rd_word;
    logic rd_hit;

    // Two stages on the detector, so a slow supply ramp cannot upset logic.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            det_meta_r <= 1'b0;
            det_r <= 1'b0;
        end else begin
            det_meta_r <= I_DETECTED_3V3;
            det_r <= det_meta_r;
        end
    end

    // One two-stage synchroniser per pin; the enable mask is applied at readback.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            always_ff @(posedge I_CLK or negedge I_NRST) begin
                if (!I_NRST) begin
                    pin_meta_r[g] <= 1'b0;
                    pin_sync_r[g] <= 1'b0;
                end else begin
                    pin_meta_r[g] <= I_PIN_LEVEL[g];
                    pin_sync_r[g] <= pin_meta_r[g];
                end
            end
        end
    endgenerate

    // Detected level as a supply field code.
    assign det_code = det_r ? `SUPPLY_33V : `SUPPLY_18V;

    // Effective controls: written values only under override.
    always_comb begin
        if (io_ctl_r[`OVERRIDE_BIT]) begin
            eff_ctrl.high_voltage = io_ctl_r[`HV_SEL_BIT];
            eff_ctrl.supply_level = io_ctl_r[`SUPPLY_HI:`SUPPLY_LO];
        end else begin
            eff_ctrl.high_voltage = det_r;
            eff_ctrl.supply_level = det_code;
        end
    end

    // Readback shows what the pads actually use, not stale writes.
    assign io_ctl_view = {eff_ctrl.high_voltage, io_ctl_r[`OVERRIDE_BIT],
                          eff_ctrl.supply_level, io_ctl_r[3:0]};

    // Registered pad outputs.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_SUPPLY_CTRL <= '0;
            O_PIN_INPUT_ENABLE <= 4'hF;
        end else begin
            O_SUPPLY_CTRL <= eff_ctrl;
            O_PIN_INPUT_ENABLE <= in_ctl_r[3:0];
        end
    end

    // Write channels: address and data are latched in either order.
    assign do_write = aw_held_r && w_held_r && wr_state_r == io_regs_pkg::WR_IDLE;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            O_AWREADY <= 1'b0;
        end else begin
            O_AWREADY <= !aw_held_r && !O_AWREADY;
            if (I_AWVALID && O_AWREADY) begin
                aw_held_r <= 1'b1;
                awaddr_r <= I_AWADDR;
                O_AWREADY <= 1'b0;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            O_WREADY <= 1'b0;
        end else begin
            O_WREADY <= !w_held_r && !O_WREADY;
            if (I_WVALID && O_WREADY) begin
                w_held_r <= 1'b1;
                wdata_r <= I_WDATA;
                wstrb_r <= I_WSTRB;
                O_WREADY <= 1'b0;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Response; addresses outside 0x030 to 0x03F get SLVERR; unmapped addresses change nothing.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            wr_state_r <= io_regs_pkg::WR_IDLE;
            O_BVALID <= 1'b0;
            O_BRESP <= `AXI_RESP_OKAY;
        end else begin
            unique case (wr_state_r)
                io_regs_pkg::WR_IDLE: begin
                    if (do_write) begin
                        wr_state_r <= io_regs_pkg::WR_RESP;
                        O_BVALID <= 1'b1;
                        O_BRESP <= (awaddr_r[11:4] == 8'h03) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
                    end
                end
                io_regs_pkg::WR_RESP: begin
                    if (I_BREADY) begin
                        wr_state_r <= io_regs_pkg::WR_IDLE;
                        O_BVALID <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Register storage; only byte lane 0 carries data.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            reserved_a_r <= `RESERVED_SLOT_A_RST;
            io_ctl_r <= `IO_SUPPLY_CONTROL_RST;
            pin_rsvd_r <= `PIN_LEVEL_STATUS_RST;
            in_ctl_r <= `PIN_INPUT_CONTROL_RST;
        end else if (do_write && wstrb_r[0]) begin
            if (awaddr_r == `BYTE_ADDR(`RESERVED_SLOT_A_ADDR)) begin
                reserved_a_r <= wdata_r[7:0];
            end
            if (awaddr_r == `BYTE_ADDR(`IO_SUPPLY_CONTROL_ADDR)) begin
                io_ctl_r <= wdata_r[7:0];
            end
            if (awaddr_r == `BYTE_ADDR(`PIN_LEVEL_STATUS_ADDR)) begin
                pin_rsvd_r[7:4] <= wdata_r[7:4];
            end
            if (awaddr_r == `BYTE_ADDR(`PIN_INPUT_CONTROL_ADDR)) begin
                in_ctl_r <= wdata_r[7:0];
            end
        end
    end

    // Read decode.
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h00000000;
        if (I_ARADDR == `BYTE_ADDR(`RESERVED_SLOT_A_ADDR)) begin
            rd_word[7:0] = reserved_a_r;
        end else if (I_ARADDR == `BYTE_ADDR(`IO_SUPPLY_CONTROL_ADDR)) begin
            rd_word[7:0] = io_ctl_view;
        end else if (I_ARADDR == `BYTE_ADDR(`PIN_LEVEL_STATUS_ADDR)) begin
            rd_word[7:0] = {pin_rsvd_r[7:4], pin_sync_r & in_ctl_r[3:0]};
        end else if (I_ARADDR == `BYTE_ADDR(`PIN_INPUT_CONTROL_ADDR)) begin
            rd_word[7:0] = in_ctl_r;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read channel: one read at a time, answered the cycle after acceptance.
    // Ready idles low every other cycle; a master that holds its request is never hurt by it.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h00000000;
            O_RRESP <= `AXI_RESP_OKAY;
        end else begin
            O_ARREADY <= !O_RVALID && !O_ARREADY;
            if (I_ARVALID && O_ARREADY) begin
                O_ARREADY <= 1'b0;
                O_RVALID <= 1'b1;
                O_RDATA <= rd_word;
                O_RRESP <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    // Accepted bus reads of the two registers whose fields the checks below follow.
    sequence s_ctl_read;
        I_ARVALID && O_ARREADY && I_ARADDR == `BYTE_ADDR(`IO_SUPPLY_CONTROL_ADDR);
    endsequence
    sequence s_status_read;
        I_ARVALID && O_ARREADY && I_ARADDR == `BYTE_ADDR(`PIN_LEVEL_STATUS_ADDR);
    endsequence

    // Under override the pads follow the written supply field one cycle later.
    a_override_path: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        io_ctl_r[`OVERRIDE_BIT] |=> O_SUPPLY_CTRL.supply_level == $past(io_ctl_r[5:4]))
        else $error("Override value not applied.");

    // Without override the select follows the synchronised detector.
    a_detect_path: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        !io_ctl_r[`OVERRIDE_BIT] |=> O_SUPPLY_CTRL.high_voltage == $past(det_r))
        else $error("Detected level not applied.");

    // The detected level only ever maps onto the two legal supply patterns.
    a_detect_code: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        !io_ctl_r[`OVERRIDE_BIT] |-> eff_ctrl.supply_level == {2{det_r}})
        else $error("Supply code mismatch.");

    // A control read without override shows the detector, not the stored select.
    a_hv_view: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        s_ctl_read ##0 !io_ctl_r[`OVERRIDE_BIT] |=> O_RDATA[`HV_SEL_BIT] == $past(det_r))
        else $error("Readback shows stored select.");

    // Likewise the supply field reads the detected pattern, not the written one.
    a_field_view: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        s_ctl_read ##0 !io_ctl_r[`OVERRIDE_BIT] |=> O_RDATA[5:4] == {2{$past(det_r)}})
        else $error("Readback shows stored supply field.");

    // Two stages per pin; counted from two edges after reset so cleared stages cannot trip it.
    a_pin_sync: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        $past(I_NRST, 2) |-> pin_sync_r == $past(I_PIN_LEVEL, 2))
        else $error("Pin synchroniser depth wrong.");

    // Enables reach the pads one register later.
    a_enable_out: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        ##1 O_PIN_INPUT_ENABLE == $past(in_ctl_r[3:0]))
        else $error("Input enable not forwarded.");

    // Status reads carry the synchronised levels masked by the enables; written low bits never show.
    a_status_ro: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        s_status_read |=> O_RDATA[7:4] == $past(pin_rsvd_r[7:4])
            && O_RDATA[3:0] == ($past(pin_sync_r) & $past(in_ctl_r[3:0])))
        else $error("Status readback wrong.");

    // With every input enabled, bit n of a status read is pin n.
    a_read_answer: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        s_status_read ##0 in_ctl_r[3:0] == 4'hF |=> O_RVALID && O_RDATA[3:0] == $past(pin_sync_r))
        else $error("Pin order in status read wrong.");
endmodule

// [testbench/pin_partner.sv]
// Model of the supply detector and the four general-purpose pins.
// Assumes the bench commands the wanted levels; they change off the register clock edge.
`timescale 1ns/1ps
module pin_partner (
    // Clock and commanded levels.
    input wire logic i_clk,
    input wire logic i_det_want,
    input wire logic [3:0] i_pin_want,
    // Levels seen by the block.
    output logic o_det,
    output logic [3:0] o_pin
);
    // Levels move on the falling edge, unrelated to sampling, so the synchronisers matter.
    always @(negedge i_clk) begin
        o_det <= i_det_want;
        o_pin <= i_pin_want;
    end
endmodule

// [testbench/test_io_supply_pin_regs.sv]
// Self-checking bench for the I/O supply and pin input register slice.
// Assumes the byte map 0x30 to 0x3C and a 2-FF input synchroniser.
`timescale 1ns/1ps
module test_io_supply_pin_regs;
    logic I_CLK = 1'b0, I_NRST = 1'b0, I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0;
    logic I_ARVALID = 1'b0, I_RREADY = 1'b0, det_want = 1'b0;
    logic [11:0] I_AWADDR = 12'h000, I_ARADDR = 12'h000;
    logic [31:0] I_WDATA = 32'h0;
    logic [3:0] I_WSTRB = 4'h0, pin_want = 4'h0, pin_lvl;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, det;
    logic [1:0] O_BRESP, O_RRESP;
    logic [31:0] O_RDATA;
    logic [3:0] O_PIN_INPUT_ENABLE;
    io_regs_pkg::supply_ctrl_type O_SUPPLY_CTRL;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] s = 8'h1A;
    int n_fail = 0, n_compared = 0;
    always #12.5 I_CLK = ~I_CLK;
    pin_partner far (.i_clk(I_CLK), .i_det_want(det_want), .i_pin_want(pin_want),
        .o_det(det), .o_pin(pin_lvl));
    io_supply_pin_regs dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_AWADDR(I_AWADDR),
        .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB),
        .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
        .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
        .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
        .I_RREADY(I_RREADY), .I_DETECTED_3V3(det), .I_PIN_LEVEL(pin_lvl),
        .O_SUPPLY_CTRL(O_SUPPLY_CTRL), .O_PIN_INPUT_ENABLE(O_PIN_INPUT_ENABLE));
    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One clock with a hang guard; a wait that runs out ends the run.
    task automatic step(inout int n);
        @(posedge I_CLK);
        n++;
        if (n > 100) begin
            n_fail++;
            wrap_up();
        end
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Write with address and data offered together; each released once taken.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        int n;
        bit aw, w;
        n = 0;
        aw = 1'b0;
        w = 1'b0;
        bq.push_back(r);
        I_AWADDR <= a;
        I_WDATA <= {24'h0, d};
        I_WSTRB <= 4'hF;
        I_AWVALID <= 1'b1;
        I_WVALID <= 1'b1;
        I_BREADY <= 1'b1;
        do begin
            step(n);
            if (!aw && O_AWREADY) begin
                aw = 1'b1;
                I_AWVALID <= 1'b0;
            end
            if (!w && O_WREADY) begin
                w = 1'b1;
                I_WVALID <= 1'b0;
            end
        end while (!(aw && w));
        do step(n); while (!O_BVALID);
        I_BREADY <= 1'b0;
        @(posedge I_CLK);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        int n;
        n = 0;
        rq.push_back({r, 24'h0, d});
        I_ARADDR <= a;
        I_ARVALID <= 1'b1;
        I_RREADY <= 1'b1;
        do step(n); while (!O_ARREADY);
        I_ARVALID <= 1'b0;
        do step(n); while (!O_RVALID);
        I_RREADY <= 1'b0;
        @(posedge I_CLK);
    endtask
    // Watcher: every completed response is matched against the oldest note.
    always @(posedge I_CLK) begin
        if (O_BVALID && I_BREADY) check({32'h0, O_BRESP}, {32'h0, bq.pop_front()});
        if (O_RVALID && I_RREADY) check({O_RRESP, O_RDATA}, rq.pop_front());
    end
    task automatic ctrl(input logic [2:0] e);
        check({31'h0, O_SUPPLY_CTRL}, {31'h0, e});
    endtask
    initial begin
        repeat (6) @(posedge I_CLK);
        I_NRST <= 1'b1;
        repeat (2) @(posedge I_CLK);
        check({30'h0, O_PIN_INPUT_ENABLE}, 34'hF);
        ctrl(3'h0);
        rd(12'h030, 8'h00);
        rd(12'h034, 8'h09);
        rd(12'h03C, 8'h7F);
        // Detector alone steers the pads while the override is clear.
        det_want <= 1'b1;
        repeat (5) @(posedge I_CLK);
        ctrl(3'h7);
        rd(12'h034, 8'hB9);
        wr(12'h034, 8'h45);
        ctrl(3'h0);
        rd(12'h034, 8'h45);
        wr(12'h034, 8'hF0);
        ctrl(3'h7);
        rd(12'h034, 8'hF0);
        // A stored select of one must read back as the detector once override drops.
        wr(12'h034, 8'h80);
        rd(12'h034, 8'hB0);
        det_want <= 1'b0;
        repeat (5) @(posedge I_CLK);
        ctrl(3'h0);
        rd(12'h034, 8'h00);
        // Enables are still at reset here, so each pin level must read straight through.
        pin_want <= 4'h5;
        repeat (4) @(posedge I_CLK);
        rd(12'h038, 8'h05);
        for (int i = 0; i < 4; i++) begin
            s = lfsr(s);
            wr(12'h03C, {4'h7, s[7:4]});
            check({30'h0, O_PIN_INPUT_ENABLE}, {30'h0, s[7:4]});
            // Inverted nibble, so high pins meet both enabled and disabled inputs.
            pin_want <= ~s[3:0];
            wr(12'h038, 8'h0F);
            repeat (4) @(posedge I_CLK);
            rd(12'h038, {4'h0, ~s[3:0] & s[7:4]});
        end
        wr(12'h040, 8'hFF, 2'h2);
        rd(12'h040, 8'h00, 2'h2);
        wrap_up();
    end
endmodule
